// file: logic/dif_cmd_core.sv
`timescale 1ns/10ps

// ==========================================
// pixel fifo
module dif_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      count;
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = (count != DEPTH[PW:0]);
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];

    always_ff @(posedge clk) begin
        if (doPush) begin
            store[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            count <= count + {{PW{1'b0}}, doPush} - {{PW{1'b0}}, doPop};
            if (doPush) wrPtr <= wrPtr + 1'b1;
            if (doPop) rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule

// What this block does
// RL1 - command 39h, no parameter, enters idle mode
// RL2 - idle shows only each component's top bit
// RL3 - idle entry while idle changes nothing
// RL4 - every reset leaves idle mode off
// RL5 - command 3Ah takes one format byte
// RL6 - bits 6..4 video, 2..0 command format
// RL7 - format bits 7 and 3 ignored
// RL8 - unused interface keeps its format field
// RL9 - format applies only to later memory writes
// RL10 - hard reset 18bpp, soft reset keeps format
// RL11 - command 3Ch streams pixel words into memory
// RL12 - continue resumes after last written pixel
// RL13 - no exchange: columns first, then pages
// RL14 - exchange: pages first, then columns
// RL15 - no wrap: excess pixel words discarded
// RL16 - wrap: pointers reset, excess written again
// RL17 - host restarts write after window changes
// RL18 - 18-bit pixel words; next command ends
// RL19 - command 38h leaves idle mode
// RL20 - select low command, high data, rising strobe
// RL21 - commands accepted in every operating state
module dif_cmd_core
    import dif_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              softReset,
    // host pins
    input  wire logic              chipSelect_n,
    input  wire logic              data_command_select,
    input  wire logic              write_strobe_n,
    input  wire logic [BUS_W-1:0]  hostData,
    output logic                   pixelInReady,
    // configuration
    input  wire logic              cmdIfUsed,
    input  wire logic              videoIfUsed,
    input  wire logic              row_column_exchange_bit,
    input  wire logic              overflow_wrap_mode,
    input  wire logic              writeStartLoad,
    input  wire logic [ADDR_W-1:0] first_column,
    input  wire logic [ADDR_W-1:0] last_column,
    input  wire logic [ADDR_W-1:0] first_page,
    input  wire logic [ADDR_W-1:0] last_page,
    // status
    output logic                   idleMode,
    output logic      [FMT_W-1:0]  cmdPixelFormat,
    output logic      [FMT_W-1:0]  videoPixelFormat,
    output logic                   windowFull,
    // frame memory write port
    output logic                   frameMemoryWrite,
    input  wire logic              frameMemoryReady,
    output logic      [ADDR_W-1:0] frameMemoryColumn,
    output logic      [ADDR_W-1:0] frameMemoryPage,
    output logic      [BUS_W-1:0]  frameMemoryData,
    output logic      [FMT_W-1:0]  frameMemoryFormat,
    // display path
    input  wire logic [BUS_W-1:0]  displayPixelIn,
    output logic      [BUS_W-1:0]  displayPixel
);
    // ==========================================
    // pin synchronisers
    logic [BUS_W+2:0] pinMeta;
    logic [BUS_W+2:0] pinSync;
    logic             strobePrev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta    <= {3'h7, {BUS_W{1'b0}}};
            pinSync    <= {3'h7, {BUS_W{1'b0}}};
            strobePrev <= 1'b1;
        end else begin
            pinMeta    <= {write_strobe_n, chipSelect_n, data_command_select, hostData};
            pinSync    <= pinMeta;
            strobePrev <= pinSync[BUS_W+2];
        end
    end

    wire             syncStrobe = pinSync[BUS_W+2];
    wire             syncSel_n  = pinSync[BUS_W+1];
    wire             syncDc     = pinSync[BUS_W];
    wire [BUS_W-1:0] syncData   = pinSync[BUS_W-1:0];
    wire             strobeRise = syncStrobe && !strobePrev && !syncSel_n; // [RL20]
    wire             cmdWrite   = strobeRise && !syncDc;                   // [RL20]
    wire             dataWrite  = strobeRise && syncDc;                    // [RL20]
    wire [OPC_W-1:0] opcode     = syncData[OPC_W-1:0];

    // ==========================================
    // command decode
    dif_state_t state;
    dif_state_t next_state;

    wire isEnter  = cmdWrite && (opcode == OPC_IDLE_ENTER);
    wire isExit   = cmdWrite && (opcode == OPC_IDLE_EXIT);
    wire isFormat = cmdWrite && (opcode == OPC_PIX_FORMAT);
    wire isStream = cmdWrite && (opcode == OPC_MEM_CONT);
    wire fmtParam = dataWrite && (state == ST_FORMAT);
    wire pixWord  = dataWrite && (state == ST_STREAM);

    always_comb begin
        next_state = state;
        case (state)
            ST_FORMAT: if (fmtParam) next_state = ST_IDLE;
            default:   next_state = state;
        endcase
        if (isFormat) next_state = ST_FORMAT;                 // [RL5] [RL21]
        else if (isStream) next_state = ST_STREAM;            // [RL11] [RL21]
        else if (cmdWrite) next_state = ST_IDLE;              // [RL18]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) state <= ST_IDLE;
        else state <= next_state;
    end

    // ==========================================
    // idle mode and pixel formats
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idleMode <= 1'b0;                                 // [RL4]
        end else if (softReset) begin
            idleMode <= 1'b0;                                 // [RL4]
        end else if (isEnter) begin
            idleMode <= 1'b1;                                 // [RL1] [RL3]
        end else if (isExit) begin
            idleMode <= 1'b0;                                 // [RL19]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdPixelFormat   <= FMT_RESET;                    // [RL10]
            videoPixelFormat <= FMT_RESET;                    // [RL10]
        end else if (fmtParam) begin
            if (cmdIfUsed) cmdPixelFormat <= syncData[FMT_CMD_LSB +: FMT_W];      // [RL6] [RL7] [RL8]
            if (videoIfUsed) videoPixelFormat <= syncData[FMT_VID_LSB +: FMT_W];  // [RL6] [RL7] [RL8]
        end
    end

    // ==========================================
    // pixel fifo, format travels with each word
    logic                   fifoOutValid;
    logic [BUS_W+FMT_W-1:0] fifoOut;

    dif_fifo #(
        .WIDTH (BUS_W + FMT_W),
        .DEPTH (FIFO_DEPTH)
    ) pixelFifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (pixWord),                                  // [RL11]
        .inReady  (pixelInReady),
        .inData   ({cmdPixelFormat, syncData}),               // [RL9] [RL18]
        .outValid (fifoOutValid),
        .outReady (frameMemoryReady || windowFull),
        .outData  (fifoOut)
    );

    // ==========================================
    // address pointers
    logic [ADDR_W-1:0] column;
    logic [ADDR_W-1:0] page;
    logic [ADDR_W-1:0] next_column;
    logic [ADDR_W-1:0] next_page;
    logic              next_full;

    wire colLast   = (column == last_column);
    wire pageLast  = (page == last_page);
    wire windowEnd = colLast && pageLast;
    wire drain     = fifoOutValid && frameMemoryReady && !windowFull;

    always_comb begin
        next_column = column;
        next_page   = page;
        next_full   = windowFull;
        if (drain) begin
            if (windowEnd) begin
                next_column = first_column;                   // [RL16]
                next_page   = first_page;                     // [RL16]
                next_full   = !overflow_wrap_mode;            // [RL15]
            end else if (!row_column_exchange_bit) begin
                if (!colLast) begin
                    next_column = column + 1'b1;              // [RL13]
                end else begin
                    next_column = first_column;               // [RL13]
                    next_page   = page + 1'b1;                // [RL13]
                end
            end else begin
                if (!pageLast) begin
                    next_page   = page + 1'b1;                // [RL14]
                end else begin
                    next_page   = first_page;                 // [RL14]
                    next_column = column + 1'b1;              // [RL14]
                end
            end
        end
        if (writeStartLoad) begin
            next_column = first_column;                       // [RL17]
            next_page   = first_page;                         // [RL17]
            next_full   = 1'b0;
        end
    end

    // pointers persist across commands so a continue resumes in place
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            column     <= ADDR_RESET;
            page       <= ADDR_RESET;
            windowFull <= 1'b0;
        end else begin
            column     <= next_column;                        // [RL12]
            page       <= next_page;                          // [RL12]
            windowFull <= next_full;                          // [RL15]
        end
    end

    assign frameMemoryWrite  = fifoOutValid && !windowFull;   // [RL15]
    assign frameMemoryColumn = column;
    assign frameMemoryPage   = page;
    assign frameMemoryData   = fifoOut[BUS_W-1:0];
    assign frameMemoryFormat = fifoOut[BUS_W +: FMT_W];       // [RL9]

    // ==========================================
    // display colour reduction
    wire [BUS_W-1:0] idlePixel = {{COMP_W{displayPixelIn[RED_MSB]}},
                                  {COMP_W{displayPixelIn[GRN_MSB]}},
                                  {COMP_W{displayPixelIn[BLU_MSB]}}};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) displayPixel <= '0;
        else displayPixel <= idleMode ? idlePixel : displayPixelIn;   // [RL2]
    end

    // ==========================================
    // checks
    idle_enter_a: assert property (@(posedge clk) disable iff (rst) // [RL1]
        isEnter && !softReset |=> idleMode)
        else $error("idle entry not taken");
    idle_again_a: assert property (@(posedge clk) disable iff (rst) // [RL3]
        idleMode && isEnter && !softReset |=> idleMode && $stable(cmdPixelFormat))
        else $error("repeat idle entry changed state");
    idle_reset_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
        softReset |=> !idleMode)
        else $error("soft reset left idle on");
    idle_exit_a: assert property (@(posedge clk) disable iff (rst) // [RL19]
        isExit && !isEnter |=> !idleMode)
        else $error("idle exit not taken");
    idle_color_a: assert property (@(posedge clk) disable iff (rst) // [RL2]
        idleMode |=> displayPixel[RED_MSB -: COMP_W] ==
            {COMP_W{$past(displayPixelIn[RED_MSB])}})
        else $error("idle colour not reduced");
    fmt_load_a: assert property (@(posedge clk) disable iff (rst) // [RL6]
        fmtParam && cmdIfUsed |=> cmdPixelFormat == $past(syncData[2:0]))
        else $error("command format not loaded");
    fmt_keep_a: assert property (@(posedge clk) disable iff (rst) // [RL10]
        softReset && !fmtParam |=> $stable(cmdPixelFormat) && $stable(videoPixelFormat))
        else $error("soft reset changed format");
    col_step_a: assert property (@(posedge clk) disable iff (rst) // [RL13]
        drain && !row_column_exchange_bit && !colLast && !writeStartLoad
            |=> column == $past(column) + 1'b1 && $stable(page))
        else $error("column did not advance");
    page_step_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
        drain && row_column_exchange_bit && !pageLast && !writeStartLoad
            |=> page == $past(page) + 1'b1 && $stable(column))
        else $error("page did not advance");
    discard_a: assert property (@(posedge clk) disable iff (rst) // [RL15]
        drain && windowEnd && !overflow_wrap_mode && !writeStartLoad
            |=> windowFull && !frameMemoryWrite)
        else $error("excess pixel not discarded");
    wrap_a: assert property (@(posedge clk) disable iff (rst) // [RL16]
        drain && windowEnd && overflow_wrap_mode
            |=> column == first_column && page == first_page && !windowFull)
        else $error("window did not wrap");
    stream_end_a: assert property (@(posedge clk) disable iff (rst) // [RL18]
        cmdWrite && !isStream && !isFormat |=> state == ST_IDLE)
        else $error("stream not ended by command");
endmodule

// file: logic/dif_pkg.sv
package dif_pkg;

    // ==========================================
    // command codes
    localparam logic [7:0] OPC_IDLE_EXIT  = 8'h38;
    localparam logic [7:0] OPC_IDLE_ENTER = 8'h39;
    localparam logic [7:0] OPC_PIX_FORMAT = 8'h3a;
    localparam logic [7:0] OPC_MEM_CONT   = 8'h3c;

    // ==========================================
    // widths and field positions
    localparam int BUS_W       = 18;
    localparam int ADDR_W      = 9;
    localparam int FMT_W       = 3;
    localparam int OPC_W       = 8;
    localparam int FMT_VID_LSB = 4;
    localparam int FMT_CMD_LSB = 0;
    localparam int RED_MSB     = 17;
    localparam int GRN_MSB     = 11;
    localparam int BLU_MSB     = 5;
    localparam int COMP_W      = 6;
    localparam int FIFO_DEPTH  = 8;

    // ==========================================
    // reset values
    localparam logic [FMT_W-1:0]  FMT_RESET  = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

    // ==========================================
    // command interpreter states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FORMAT,
        ST_STREAM
    } dif_state_t;

endpackage

// file: verif/dif_host_model.sv
`timescale 1ns/10ps

// ==========================================
// host bus model
module dif_host_model
    import dif_pkg::*;
(
    // clock
    input  wire logic             clk,
    // host pins
    output logic                  chipSelect_n,
    output logic                  data_command_select,
    output logic                  write_strobe_n,
    output logic      [BUS_W-1:0] hostData
);
    initial begin
        chipSelect_n        = 1'b1;
        data_command_select = 1'b1;
        write_strobe_n      = 1'b1;
        hostData            = '0;
    end

    // one word per strobe, each phase four clocks
    task automatic send(input logic isData, input logic [BUS_W-1:0] word);
        @(posedge clk);
        chipSelect_n        <= 1'b0;
        data_command_select <= isData;
        hostData            <= word;
        write_strobe_n      <= 1'b0;
        repeat (4) @(posedge clk);
        write_strobe_n      <= 1'b1;
        repeat (4) @(posedge clk);
        hostData            <= ~word;
    endtask
endmodule

// file: verif/dif_cmd_core_tb_top.sv
`timescale 1ns/10ps

// ==========================================
// bench top
module dif_cmd_core_tb_top
    import dif_pkg::*;
;
    logic              clk = 1'b0, rst = 1'b1, softReset = 1'b0;
    logic              csN, dcs, wrN, pixelInReady, cmdIfUsed = 1'b1, videoIfUsed = 1'b1;
    logic [BUS_W-1:0]  hostData, frameMemoryData, displayPixel;
    logic [BUS_W-1:0]  displayPixelIn = 18'h25673;
    logic              exch = 1'b0, wrap = 1'b0, writeStartLoad = 1'b0, frameMemoryReady = 1'b1;
    logic [ADDR_W-1:0] fc = '0, lc = '0, fp = '0, lp = '0, frameMemoryColumn, frameMemoryPage;
    logic              idleMode, windowFull, frameMemoryWrite;
    logic [FMT_W-1:0]  cmdPixelFormat, videoPixelFormat, frameMemoryFormat;
    logic [38:0]       wrQ[$];
    int                bad_count = 0, tests_run = 0;

    always #20 clk = ~clk;

    dif_host_model host (.clk(clk), .chipSelect_n(csN), .data_command_select(dcs),
        .write_strobe_n(wrN), .hostData(hostData));

    dif_cmd_core dut (.clk(clk), .rst(rst), .softReset(softReset), .chipSelect_n(csN),
        .data_command_select(dcs), .write_strobe_n(wrN), .hostData(hostData),
        .pixelInReady(pixelInReady), .cmdIfUsed(cmdIfUsed), .videoIfUsed(videoIfUsed),
        .row_column_exchange_bit(exch), .overflow_wrap_mode(wrap),
        .writeStartLoad(writeStartLoad), .first_column(fc), .last_column(lc),
        .first_page(fp), .last_page(lp), .idleMode(idleMode), .cmdPixelFormat(cmdPixelFormat),
        .videoPixelFormat(videoPixelFormat), .windowFull(windowFull),
        .frameMemoryWrite(frameMemoryWrite), .frameMemoryReady(frameMemoryReady),
        .frameMemoryColumn(frameMemoryColumn), .frameMemoryPage(frameMemoryPage),
        .frameMemoryData(frameMemoryData), .frameMemoryFormat(frameMemoryFormat),
        .displayPixelIn(displayPixelIn), .displayPixel(displayPixel));

    // ==========================================
    // memory side monitor
    always @(posedge clk) begin
        if (frameMemoryWrite === 1'b1 && frameMemoryReady)
            wrQ.push_back({frameMemoryFormat, frameMemoryColumn, frameMemoryPage, frameMemoryData});
    end

    // ==========================================
    // helpers
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [38:0] seen, input logic [38:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        host.send(1'b0, {10'h000, op});
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_writes(input int n);
        int k;
        for (k = 0; k < 300 && wrQ.size() < n; k++) @(posedge clk);
        if (wrQ.size() < n) begin
            bad_count++;
            finish_test();
        end
        repeat (20) @(posedge clk);
    endtask

    task automatic open_window(input logic x, w, input logic [8:0] c0, c1, p0, p1);
        @(posedge clk);
        exch <= x; wrap <= w; fc <= c0; lc <= c1; fp <= p0; lp <= p1;
        writeStartLoad <= 1'b1;
        @(posedge clk);
        writeStartLoad <= 1'b0;
        wrQ.delete();
    endtask

    task automatic exp_wr(input logic [8:0] c, p, input logic [17:0] d);
        check("frame write", wrQ.pop_front(), {3'h5, c, p, d});
    endtask

    // ==========================================
    // scenarios
    task automatic t_idle();
        cmd(OPC_IDLE_ENTER);
        check("idle on", idleMode, 1'b1);
        check("idle pixel", displayPixel, {6'h3f, 6'h00, 6'h3f});
        cmd(OPC_IDLE_ENTER);
        check("idle again", idleMode, 1'b1);
        cmd(OPC_IDLE_EXIT);
        check("idle off", idleMode, 1'b0);
        check("full pixel", displayPixel, 18'h25673);
        cmd(OPC_IDLE_ENTER);
        @(posedge clk) softReset <= 1'b1;
        @(posedge clk) softReset <= 1'b0;
        @(posedge clk);
        check("soft idle", idleMode, 1'b0);
    endtask

    task automatic t_format();
        cmd(OPC_PIX_FORMAT);
        host.send(1'b1, 18'h3ffb5);
        repeat (3) @(posedge clk);
        check("vid fmt", videoPixelFormat, 3'h3);
        check("cmd fmt", cmdPixelFormat, 3'h5);
        @(posedge clk) cmdIfUsed <= 1'b0;
        cmd(OPC_PIX_FORMAT);
        host.send(1'b1, 18'h00022);
        repeat (3) @(posedge clk);
        check("unused if", cmdPixelFormat, 3'h5);
        check("used if", videoPixelFormat, 3'h2);
        @(posedge clk) begin cmdIfUsed <= 1'b1; softReset <= 1'b1; end
        @(posedge clk) softReset <= 1'b0;
        @(posedge clk);
        check("soft fmt", cmdPixelFormat, 3'h5);
    endtask

    task automatic t_discard();
        int i;
        open_window(1'b0, 1'b0, 9'h002, 9'h004, 9'h001, 9'h002);
        cmd(OPC_MEM_CONT);
        for (i = 0; i < 7; i++) host.send(1'b1, 18'h00100 + i);
        wait_writes(6);
        check("discard count", wrQ.size(), 6);
        check("window full", windowFull, 1'b1);
        for (i = 0; i < 6; i++) exp_wr(2 + i % 3, 1 + i / 3, 18'h00100 + i);
    endtask

    task automatic t_wrap();
        int i;
        open_window(1'b1, 1'b1, 9'h002, 9'h004, 9'h001, 9'h002);
        cmd(OPC_MEM_CONT);
        for (i = 0; i < 4; i++) host.send(1'b1, 18'h00200 + i);
        cmd(OPC_IDLE_ENTER);
        check("idle in stream", idleMode, 1'b1);
        cmd(OPC_MEM_CONT);
        for (i = 4; i < 7; i++) host.send(1'b1, 18'h00200 + i);
        wait_writes(7);
        check("wrap count", wrQ.size(), 7);
        check("no full", windowFull, 1'b0);
        for (i = 0; i < 6; i++) exp_wr(2 + i / 2, 1 + i % 2, 18'h00200 + i);
        exp_wr(9'h002, 9'h001, 18'h00206);
    endtask

    task automatic t_fifo();
        int i;
        open_window(1'b0, 1'b0, 9'h000, 9'h00f, 9'h000, 9'h000);
        @(posedge clk) frameMemoryReady <= 1'b0;
        cmd(OPC_MEM_CONT);
        for (i = 0; i < 9; i++) host.send(1'b1, 18'h00300 + i);
        repeat (3) @(posedge clk);
        check("fifo full", pixelInReady, 1'b0);
        check("stalled write", frameMemoryWrite, 1'b1);
        cmd(OPC_PIX_FORMAT);
        host.send(1'b1, 18'h00001);
        repeat (3) @(posedge clk);
        check("late fmt", cmdPixelFormat, 3'h1);
        @(posedge clk) frameMemoryReady <= 1'b1;
        wait_writes(8);
        check("fifo count", wrQ.size(), 8);
        check("drained", frameMemoryWrite, 1'b0);
        for (i = 0; i < 8; i++) exp_wr(i, 9'h000, 18'h00300 + i);
    endtask

    task automatic t_reset(input string when);
        check({when, " idle"}, idleMode, 1'b0);
        check({when, " cmd fmt"}, cmdPixelFormat, 3'h6);
        check({when, " vid fmt"}, videoPixelFormat, 3'h6);
        check({when, " ready"}, pixelInReady, 1'b1);
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset("power");
        t_idle();
        t_format();
        t_discard();
        t_wrap();
        t_fifo();
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset("hard");
        finish_test();
    end
endmodule
